// [hw/option_hold.sv]
// holding bank for the two option bytes
// assumes: load strobes come only from the reset-time sequencer
`timescale 1ns/100ps
`include "optload_defines.svh"

module option_hold (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // load strobes and flash data
    input wire logic load_zero,
    input wire logic load_one,
    input wire logic [7:0] flash_byte,
    // held configuration
    output optload_pkg::opt_zero_t opt_zero_q,
    output optload_pkg::opt_one_t opt_one_q
);
    import optload_pkg::*;

    // ============================================================
    // byte zero, erased value until the first load
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_zero_q <= opt_zero_t'(`OPT_ERASED);
        end else if (load_zero) begin
            opt_zero_q <= opt_zero_t'(flash_byte);
        end
    end

    // byte one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_one_q <= opt_one_t'(`OPT_ERASED);
        end else if (load_one) begin
            opt_one_q <= opt_one_t'(flash_byte);
        end
    end

    hold_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        !load_zero && !load_one |=> $stable(opt_zero_q) && $stable(opt_one_q))
        else $error("option bank changed without a load");

endmodule : option_hold

// [hw/option_loader.sv]
// option byte loader: copies the user option bytes out of flash on every
// reset and drives the configuration of watchdog, oscillator, brown-out,
// debugger and flash controller from them
// assumes: flash answers a read one clock after flash_rd_en, same clock;
// stop_recovery is a one-cycle pulse from logic on pclk
//
// Summary of operation
// - action bit 0: time-out raises interrupt
// - action bit 1: time-out resets system
// - always-on 0: watchdog runs, cannot stop
// - always-on 1: start by instruction, sticky
// - drive field selects RC/min/med/max oscillator
// - brown-out off in stop needs control bit
// - brown-out always-on 1: never off
// - read protect 0: code hidden, debug limited
// - read protect 1: code open, debug full
// - write protect 0: user erase/program blocked
// - write protect 1: program and erase allowed
// - crystal bit never selects system clock
// - crystal bit 0 runs crystal, longer reset
// - load options on every reset first
// - holding registers hidden from software
`timescale 1ns/100ps
`include "optload_defines.svh"

module option_loader (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset sources and core hold
    input wire logic stop_recovery,
    output logic cpu_hold,
    // flash read port
    output logic flash_rd_en,
    output logic [15:0] flash_addr,
    input wire logic [7:0] flash_rdata,
    // watchdog
    input wire logic watchdog_enable_instruction,
    input wire logic wdt_timeout,
    output logic wdt_run,
    output logic wdt_irq_req,
    output logic wdt_sys_reset,
    // oscillator
    output optload_pkg::osc_mode_t osc_mode,
    output logic crystal_en,
    // brown-out
    input wire logic stop_mode,
    output logic brownout_en,
    // debugger and flash controller
    output logic user_code_read_en,
    output logic debug_full_en,
    input wire logic user_prog_req,
    output logic user_prog_grant,
    input wire logic debug_mass_erase_req,
    output logic mass_erase_grant
);
    import optload_pkg::*;

    // ============================================================
    // declarations
    load_state_t state_q;
    load_state_t state_d;
    logic [`SETTLE_W-1:0] settle_q;
    opt_zero_t opt_zero_q;
    opt_one_t opt_one_q;
    logic load_zero;
    logic load_one;
    logic wdt_run_q;
    logic wdt_irq_q;
    logic wdt_rst_q;
    logic bo_stop_off_q;
    logic xtal_run_q;
    logic [31:0] prdata_q;
    logic setup_rd;
    logic access_wr;
    logic loaded;

    // ============================================================
    // register decode, shared by write and error paths
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == `OFS_CTRL) || (a == `OFS_STAT);
    endfunction : reg_hit

    // ============================================================
    // load sequencer
    // read both bytes before release
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            LD_READ0: state_d = LD_CAP0;
            LD_CAP0: state_d = LD_CAP1;
            // only a running crystal needs the start-up stretch
            LD_CAP1: state_d = flash_rdata[4] ? LD_RUN : LD_SETTLE;
            LD_SETTLE: state_d = (settle_q == '0) ? LD_RUN : LD_SETTLE;
            LD_RUN: state_d = LD_RUN;
        endcase
        if (stop_recovery) begin
            state_d = LD_READ0;
        end
    end

    // state register, reset starts a load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= LD_READ0;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q <= '0;
        end else if (state_q == LD_CAP1) begin
            settle_q <= `SETTLE_W'(`XTAL_SETTLE_CYC - 1);
        end else if (state_q == LD_SETTLE && settle_q != '0) begin
            settle_q <= settle_q - 1'b1;
        end
    end

    // flash address follows the sequencer, one read per byte
    always_comb begin
        flash_rd_en = (state_q == LD_READ0) || (state_q == LD_CAP0);
        flash_addr = (state_q == LD_CAP0) ? `FLASH_OPT1_ADDR : `FLASH_OPT0_ADDR;
    end

    // data of a read arrives one cycle after its request
    assign load_zero = (state_q == LD_CAP0);
    assign load_one = (state_q == LD_CAP1);
    assign loaded = (state_q == LD_RUN);
    assign cpu_hold = !loaded;

    // ============================================================
    // bank loads only from sequencer
    option_hold u_hold (
        .clk(pclk),
        .rst_n(presetn),
        .load_zero(load_zero),
        .load_one(load_one),
        .flash_byte(flash_rdata),
        .opt_zero_q(opt_zero_q),
        .opt_one_q(opt_one_q)
    );

    // ============================================================
    // watchdog enable
    // auto start or sticky start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_run_q <= 1'b0;
        end else if (stop_recovery && opt_zero_q.watchdog_always_on) begin
            wdt_run_q <= 1'b0;
        end else if (loaded && !opt_zero_q.watchdog_always_on) begin
            wdt_run_q <= 1'b1;
        end else if (loaded && (watchdog_enable_instruction || (access_wr
                && paddr == `OFS_CTRL && pwdata[`CTRL_WDT_START]))) begin
            wdt_run_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_irq_q <= 1'b0;
            wdt_rst_q <= 1'b0;
        end else begin
            wdt_irq_q <= wdt_timeout && wdt_run_q
                && !opt_zero_q.watchdog_action_select;
            wdt_rst_q <= wdt_timeout && wdt_run_q
                && opt_zero_q.watchdog_action_select;
        end
    end

    assign wdt_run = wdt_run_q;
    assign wdt_irq_req = wdt_irq_q;
    assign wdt_sys_reset = wdt_rst_q;

    // ============================================================
    // oscillator
    // drive mode straight from field
    assign osc_mode = opt_zero_q.oscillator_drive_select;

    // crystal run after reset is software's; clock select lives elsewhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_run_q <= 1'b0;
        end else if (load_one) begin
            xtal_run_q <= !flash_rdata[4];
        end else if (loaded && access_wr && paddr == `OFS_CTRL) begin
            xtal_run_q <= pwdata[`CTRL_XTAL_RUN];
        end
    end

    assign crystal_en = cpu_hold ? !opt_one_q.crystal_off_at_reset : xtal_run_q;

    // ============================================================
    // brown-out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bo_stop_off_q <= 1'b0;
        end else if (access_wr && paddr == `OFS_CTRL) begin
            bo_stop_off_q <= pwdata[`CTRL_BO_STOP_OFF];
        end
    end

    // off only in stop, when allowed
    assign brownout_en = !(stop_mode && !opt_zero_q.brownout_always_on
        && bo_stop_off_q);

    // ============================================================
    // protection
    // read protect gating
    assign user_code_read_en = opt_zero_q.read_protect;
    assign debug_full_en = opt_zero_q.read_protect;
    assign user_prog_grant = user_prog_req && opt_zero_q.write_protect && loaded;
    // debugger mass erase stays open whatever the protection
    assign mass_erase_grant = debug_mass_erase_req;

    // ============================================================
    // apb slave, zero wait states
    // holding bytes never on the bus
    assign setup_rd = psel && !penable && !pwrite;
    assign access_wr = psel && penable && pwrite && reg_hit(paddr);

    // read data captured in setup so it comes out of a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_q <= 32'h0000_0000;
            if (paddr == `OFS_CTRL) begin
                prdata_q[`CTRL_BO_STOP_OFF] <= bo_stop_off_q;
                prdata_q[`CTRL_XTAL_RUN] <= xtal_run_q;
            end else if (paddr == `OFS_STAT) begin
                prdata_q[`STAT_LOADED] <= loaded;
                prdata_q[`STAT_WDT_RUN] <= wdt_run_q;
                prdata_q[`STAT_XTAL_RUN] <= crystal_en;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    // unmapped offsets answer with an error, writes are dropped
    assign pslverr = psel && penable && !reg_hit(paddr);

    // ============================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wdt_irq_path_a: assert property (wdt_timeout && wdt_run
        && !opt_zero_q.watchdog_action_select
        |=> wdt_irq_req && !wdt_sys_reset)
        else $error("time-out did not raise interrupt");

    wdt_reset_path_a: assert property (wdt_timeout && wdt_run
        && opt_zero_q.watchdog_action_select
        |=> wdt_sys_reset && !wdt_irq_req)
        else $error("time-out did not reset system");

    wdt_auto_on_a: assert property ($rose(loaded)
        && !opt_zero_q.watchdog_always_on |=> wdt_run)
        else $error("watchdog not started after load");

    wdt_sticky_a: assert property (wdt_run && !stop_recovery |=> wdt_run)
        else $error("watchdog stopped without reset");

    // drive mode mapping
    // checked against the flash byte, so a wrong bit pick shows up
    osc_map_a: assert property (load_zero
        |=> osc_mode == osc_mode_t'($past(flash_rdata[5:4])))
        else $error("oscillator mode differs from field");

    // brown-out off only with control bit
    bo_stop_a: assert property (!brownout_en |-> stop_mode && bo_stop_off_q)
        else $error("brown-out dropped without control bit");

    bo_always_a: assert property (opt_zero_q.brownout_always_on
        |-> brownout_en)
        else $error("brown-out off while always-on");

    // debugger scope follows read protect
    // the flash byte, not the held copy, is the reference here
    read_guard_a: assert property (load_zero |=>
        debug_full_en == $past(flash_rdata[2]) && user_code_read_en == $past(flash_rdata[2]))
        else $error("read protection mismatch");

    write_guard_a: assert property (!opt_zero_q.write_protect
        |-> !user_prog_grant && (mass_erase_grant == debug_mass_erase_req))
        else $error("protected flash granted to user");

    write_open_a: assert property (opt_zero_q.write_protect && loaded
        && user_prog_req |-> user_prog_grant)
        else $error("open flash not granted");

    load_hold_a: assert property ($rose(flash_rd_en) |-> cpu_hold [*3])
        else $error("core released before options loaded");

    xtal_stretch_a: assert property (state_q == LD_CAP1 && !flash_rdata[4]
        |=> cpu_hold [*8])
        else $error("crystal start-up stretch too short");

    // crystal enable during reset follows option only
    xtal_reset_a: assert property (cpu_hold && state_q == LD_SETTLE
        |-> crystal_en)
        else $error("crystal off during start-up stretch");

    // bus never shows the option bytes
    bus_hidden_a: assert property (setup_rd && !reg_hit(paddr)
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");

endmodule : option_loader

// [hw/optload_defines.svh]
// constants for the option byte loader: offsets, field positions, timing
// assumes: included by bare name from every design file that needs it
`ifndef OPTLOAD_DEFINES_SVH
`define OPTLOAD_DEFINES_SVH

// ============================================================
// flash locations of the two user option bytes
`define FLASH_OPT0_ADDR 16'h0000
`define FLASH_OPT1_ADDR 16'h0001
// erased flash reads as all ones
`define OPT_ERASED 8'hFF

// ============================================================
// apb register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004

// control register bits
`define CTRL_WDT_START 0
`define CTRL_BO_STOP_OFF 1
`define CTRL_XTAL_RUN 2
// status register bits
`define STAT_LOADED 0
`define STAT_WDT_RUN 1
`define STAT_XTAL_RUN 2

// ============================================================
// timing: clock rate and crystal start-up stretch of reset
`define CLK_MHZ 100
`define XTAL_SETTLE_NS 2000
`define XTAL_SETTLE_CYC ((`XTAL_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_W 8

`endif

// [hw/optload_pkg.sv]
// types shared by the option byte loader and its holding bank
// assumes: compiled before every module that imports it
package optload_pkg;

    // ============================================================
    // oscillator drive modes, in field encoding order
    typedef enum logic [1:0] {
        OSC_EXT_RC,
        OSC_MIN_POWER,
        OSC_MED_POWER,
        OSC_MAX_POWER
    } osc_mode_t;

    // first option byte layout, msb first
    typedef struct packed {
        logic watchdog_action_select;
        logic watchdog_always_on;
        osc_mode_t oscillator_drive_select;
        logic brownout_always_on;
        logic read_protect;
        logic reserved_one;
        logic write_protect;
    } opt_zero_t;

    // second option byte layout, msb first
    typedef struct packed {
        logic [2:0] reserved_hi;
        logic crystal_off_at_reset;
        logic [3:0] reserved_lo;
    } opt_one_t;

    // load sequencer states
    typedef enum logic [2:0] {
        LD_READ0,
        LD_CAP0,
        LD_CAP1,
        LD_SETTLE,
        LD_RUN
    } load_state_t;

endpackage : optload_pkg

// [test/flash_model.sv]
// behavioural flash array holding the two user option bytes
// assumes: read request sampled at rising pclk, byte shown the next cycle
`timescale 1ns/100ps

module flash_model (
    // clock
    input wire logic pclk,
    // read port
    input wire logic flash_rd_en,
    input wire logic [15:0] flash_addr,
    output logic [7:0] flash_rdata,
    // stored option bytes, changeable at any time
    input wire logic [7:0] byte_zero,
    input wire logic [7:0] byte_one
);
    // ============================================================
    // read path
    logic [7:0] data_q = 8'h5A;

    // reserved bits always programmed high
    // outside a request the bus toggles, so a stale byte never passes as fresh
    always_ff @(posedge pclk) begin
        if (flash_rd_en) begin
            if (flash_addr == 16'h0000) begin
                data_q <= byte_zero | 8'h02;
            end else if (flash_addr == 16'h0001) begin
                data_q <= byte_one | 8'hEF;
            end else begin
                data_q <= 8'hFF;
            end
        end else begin
            data_q <= ~data_q;
        end
    end

    assign flash_rdata = data_q;
endmodule : flash_model

// [test/tb_flash_option_byte_decoder.sv]
// self-checking bench for the option byte loader
// assumes: flash_model answers the loader's reads; apb has no wait states
`timescale 1ns/100ps

module tb_flash_option_byte_decoder;
    import optload_pkg::*;
    // ============================================================
    // signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ctl;
    logic stop_recovery, cpu_hold, flash_rd_en, err;
    logic [15:0] flash_addr;
    logic [7:0] flash_rdata, fb0, fb1, b0, b1;
    logic watchdog_enable_instruction, wdt_timeout, wdt_run, wdt_irq_req, wdt_sys_reset;
    logic crystal_en, stop_mode, brownout_en, user_code_read_en, debug_full_en;
    logic user_prog_req, user_prog_grant, debug_mass_erase_req, mass_erase_grant;
    logic exp_run, exp_xtal, exp_bo;
    osc_mode_t osc_mode;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 21383;
    int n, i;

    option_loader u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_recovery(stop_recovery), .cpu_hold(cpu_hold),
        .flash_rd_en(flash_rd_en), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
        .watchdog_enable_instruction(watchdog_enable_instruction),
        .wdt_timeout(wdt_timeout), .wdt_run(wdt_run), .wdt_irq_req(wdt_irq_req),
        .wdt_sys_reset(wdt_sys_reset), .osc_mode(osc_mode), .crystal_en(crystal_en),
        .stop_mode(stop_mode), .brownout_en(brownout_en),
        .user_code_read_en(user_code_read_en), .debug_full_en(debug_full_en),
        .user_prog_req(user_prog_req), .user_prog_grant(user_prog_grant),
        .debug_mass_erase_req(debug_mass_erase_req), .mass_erase_grant(mass_erase_grant));

    flash_model u_flash (.pclk(pclk), .flash_rd_en(flash_rd_en), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .byte_zero(fb0), .byte_one(fb1));

    // ============================================================
    // clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ============================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // one apb transfer; an idle edge follows so the next request never lands in this step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        if (k == 20) begin
            $display("mismatch at %0t: apb answer timed out", $time);
            num_errors++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // counts edges until the core is let go; bounded
    task automatic wait_load();
        n = 0;
        while (cpu_hold !== 1'b0) begin
            @(posedge pclk);
            n++;
            if (n > 1000) begin
                $display("mismatch at %0t: option load timed out", $time);
                num_errors++;
                conclude();
            end
        end
    endtask : wait_load

    // every configuration output against the bench's model
    task automatic check_all();
        chk(osc_mode, b0[5:4], "oscillator mode"); // drive field
        chk(user_code_read_en, b0[2], "code read");
        chk(debug_full_en, b0[2], "debug full");
        chk(user_prog_grant, user_prog_req & b0[0], "program grant");
        chk(mass_erase_grant, debug_mass_erase_req, "mass erase"); // debugger path
        chk(wdt_run, exp_run, "watchdog run");
        chk(brownout_en, !(stop_mode & !b0[3] & exp_bo), "brown-out");
        chk(crystal_en, exp_xtal, "crystal");
    endtask : check_all

    // ============================================================
    // main sequence: erased bytes first, then random option bits with the watchdog and crystal bits stepped by the loop, reloaded by
    // reset and stop-mode recovery in turn
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        stop_recovery = 1'b0;
        watchdog_enable_instruction = 1'b0;
        wdt_timeout = 1'b0;
        stop_mode = 1'b0;
        user_prog_req = 1'b0;
        debug_mass_erase_req = 1'b0;
        fb0 = 8'hFF;
        fb1 = 8'hFF;
        repeat (10) @(posedge pclk);
        for (i = 0; i < 6; i++) begin
            if (i > 0) begin
                fb0 <= {i[2:1], 6'($random(seed)) & 6'h3D} | 8'h02;
                fb1 <= {3'h7, i[0], 4'hF}; // no shared debug pin here
                repeat (3) @(posedge pclk);
                check_all(); // flash changed, held bytes kept
                stop_mode <= 1'b0;
            end
            b0 = fb0 | 8'h02;
            b1 = fb1 | 8'hEF;
            if (i[0]) begin
                stop_recovery <= 1'b1;
                @(posedge pclk);
                stop_recovery <= 1'b0;
                @(posedge pclk);
            end else begin
                presetn <= 1'b0;
                exp_bo = 1'b0;
                repeat (2) @(posedge pclk);
                presetn <= 1'b1;
            end
            wait_load();
            // automatic watchdog start lands one edge after the release
            @(posedge pclk);
            chk(n >= 200, !b1[4], "reset stretch"); // crystal start-up
            exp_run = !b0[6];
            exp_xtal = !b1[4];
            check_all();
            ctl = 32'($random(seed)) & 32'h6;
            apb(1'b1, 12'h000, ctl);
            exp_bo = ctl[1];
            exp_xtal = ctl[2];
            stop_mode <= 1'($random(seed));
            user_prog_req <= 1'($random(seed));
            debug_mass_erase_req <= 1'($random(seed));
            repeat (2) @(posedge pclk);
            check_all(); // crystal apart from mode
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, {29'h0, exp_xtal, exp_run, 1'b1}, "status"); // loaded flag
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, {29'h0, exp_xtal, exp_bo, 1'b0}, "control");
            if (!exp_run) begin
                if (i[0]) begin
                    watchdog_enable_instruction <= 1'b1;
                    @(posedge pclk);
                    watchdog_enable_instruction <= 1'b0;
                    @(posedge pclk);
                end else begin
                    apb(1'b1, 12'h000, ctl | 32'h1);
                end
                exp_run = 1'b1;
            end
            wdt_timeout <= 1'b1;
            @(posedge pclk);
            wdt_timeout <= 1'b0;
            @(posedge pclk);
            chk(wdt_irq_req, !b0[7], "watchdog irq");
            chk(wdt_sys_reset, b0[7], "watchdog reset");
            @(posedge pclk);
            chk({wdt_irq_req, wdt_sys_reset}, 2'b00, "single pulse");
            apb(1'b1, 12'h000, ctl);
            check_all(); // no stop once running
            apb(1'b0, 12'h008, 32'h0);
            chk(rd, 32'h0, "unmapped read"); // options hidden
            chk(err, 1'b1, "unmapped error"); // error on unmapped offset
            $display("config %0d done", i);
        end
        conclude();
    end
endmodule : tb_flash_option_byte_decoder
